/* core/tnp_pkg.sv */
// three nibble io ports: shared constants, register indexes and types
// assumes a 200 MHz system clock and an AHB-Lite register bus
package tnp_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int NPIN  = 12;
    localparam int NBIT  = 4;
    localparam int NPORT = 3;

    // ------------------------------------------------------------
    // register indexes, byte address is four times the index
    // ------------------------------------------------------------
    localparam int         ADDR_LSB          = 2;
    localparam int         ADDR_MSB          = 9;
    localparam logic [7:0] IDX_FIRST_DATA    = 8'h00;
    localparam logic [7:0] IDX_SECOND_DATA   = 8'h01;
    localparam logic [7:0] IDX_THIRD_DATA    = 8'h02;
    localparam logic [7:0] IDX_SHARED_CTRL   = 8'h08;
    localparam logic [7:0] IDX_ALT_SELECT    = 8'h09;
    localparam logic [7:0] IDX_PIN_CTRL      = 8'h10;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int         CTL_IE     = 3;
    localparam int         CTL_FSEL   = 2;
    localparam int         CTL_DIR    = 1;
    localparam int         CTL_MOD    = 0;
    localparam int         PULL_BIT   = 0;
    localparam int         ALT_TXD    = 0;
    localparam int         ALT_OVF    = 1;
    localparam logic [3:0] DATA_RESET = 4'h0;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic       PULL_RESET = 1'b0;
    localparam logic [1:0] ALT_RESET  = 2'h0;

    // ------------------------------------------------------------
    // pins carrying secondary functions
    // ------------------------------------------------------------
    localparam int PIN_TRG = 0;
    localparam int PIN_RXD = 1;
    localparam int PIN_ECK = 2;
    localparam int PIN_TXD = 10;
    localparam int PIN_OVF = 11;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ     = 200_000_000;
    localparam int SAMPLE_HZ  = 64;
    localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    localparam int DIV_W      = 22;
    localparam int HTRANS_ACT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [2:0] {MC_IDLE, MC_S1, MC_S2, MC_S3, MC_S4} tnp_mc_t;

endpackage : tnp_pkg

/* core/tnp_pin.sv */
// three nibble io ports: one pin's drive, termination and change detect
// assumes pin_in is synchronous to clk and tick is a one-cycle pulse
module tnp_pin
    import tnp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [3:0] ctrl,
    input  wire logic       pull_up,
    input  wire logic       out_val,
    input  wire logic       pin_in,
    input  wire logic       tick,
    output logic            pin_out,
    output logic            pin_oe,
    output logic            pu_en,
    output logic            pd_en,
    output logic            irq
);

    // ------------------------------------------------------------
    // drive and termination
    // ------------------------------------------------------------
    logic sample_en;
    logic prev_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
            pu_en   <= 1'b0;
            pd_en   <= 1'b0;
        end else begin
            pin_out <= ctrl[CTL_MOD] ? 1'b0 : out_val;
            pin_oe  <= ctrl[CTL_DIR] & (~ctrl[CTL_MOD] | ~out_val);
            pu_en   <= ~ctrl[CTL_DIR] & ~ctrl[CTL_MOD] & pull_up;
            pd_en   <= ~ctrl[CTL_DIR] & ~ctrl[CTL_MOD] & ~pull_up;
        end
    end

    // ------------------------------------------------------------
    // level change detect
    // ------------------------------------------------------------
    assign sample_en = ctrl[CTL_FSEL] | tick;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q <= 1'b0;
            irq    <= 1'b0;
        end else begin
            if (sample_en) begin
                prev_q <= pin_in;
            end
            irq <= sample_en & ctrl[CTL_IE] & (pin_in != prev_q);
        end
    end

endmodule : tnp_pin

/* core/tnp_ports.sv */
// three nibble io ports: register file, bus slave and pin array
// assumes an AHB-Lite master, pins synchronous to clk, one 200 MHz clock
//
// Notes on behaviour
// - three 4-bit ports, every one of twelve pins input or output
// - each pin picks resistor or high-z input, push-pull or open-drain output
// - one shared bit picks pull-up or pull-down for all ports
// - every pin can raise an interrupt on input level change
// - first port bit 0 feeds the timer capture trigger
// - first port bit 1 feeds serial receive data
// - first port bit 2 feeds the timer external count clock
// - third port bit 2 can output serial transmit data instead of latch
// - third port bit 3 can output timer overflow instead of latch
// - direction bit 1 set drives the pin from the data latch
// - read returns latch for output bits, pin level for input bits
// - one read mixes latch and pin bits, chosen per bit by direction
// - reset clears all three data latches to zero
// - a written value reaches the pin after step S4 of the access
// - read value is captured at step S2 of the access
// - reset clears the shared pull-direction bit
// - per-pin control: irq enable, sample clock, direction, style; reset zero
module tnp_ports
    import tnp_pkg::*;
#(
    parameter int SAMPLE_CYCLES = SAMPLE_DIV
)
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [11:0] pin_i,
    output logic [11:0]      pin_o,
    output logic [11:0]      pin_oe,
    output logic [11:0]      pin_pu_en,
    output logic [11:0]      pin_pd_en,
    output logic [11:0]      pin_irq,
    input  wire logic        serial_tx_data,
    input  wire logic        timer_overflow_flag,
    output logic             timer_capture_trigger,
    output logic             serial_rx_data,
    output logic             timer_external_clock
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    tnp_mc_t                        mc_q;
    logic [7:0]                     addr_q;
    logic                           wr_q;
    logic [NPORT-1:0][NBIT-1:0]     data_q;
    logic [NPIN-1:0][3:0]           ctrl_q;
    logic                           pull_up_q;
    logic [1:0]                     alt_q;
    logic [DIV_W-1:0]               div_q;
    logic                           tick_q;
    logic                           accept;
    logic [NPIN-1:0]                dir_w;
    logic [NPIN-1:0]                latch_w;
    logic [NPIN-1:0]                out_w;
    logic [31:0]                    rd_d;

    assign accept  = hsel & hready & htrans[HTRANS_ACT];
    assign latch_w = data_q;

    // ------------------------------------------------------------
    // access sequencer: S1..S4 per data phase
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mc_q   <= MC_IDLE;
            addr_q <= 8'h00;
            wr_q   <= 1'b0;
        end else begin
            unique case (mc_q)
                MC_IDLE, MC_S4: begin
                    if (accept) begin
                        mc_q   <= MC_S1;
                        addr_q <= haddr[ADDR_MSB:ADDR_LSB];
                        wr_q   <= hwrite;
                    end else begin
                        mc_q <= MC_IDLE;
                    end
                end
                MC_S1: begin
                    mc_q <= MC_S2;
                end
                MC_S2: begin
                    mc_q <= MC_S3;
                end
                MC_S3: begin
                    mc_q <= MC_S4;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hreadyout <= 1'b1;
        end else if ((mc_q == MC_IDLE || mc_q == MC_S4) && accept) begin
            hreadyout <= 1'b0;
        end else if (mc_q == MC_S3) begin
            hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hresp <= HRESP_OKAY;
        end else begin
            hresp <= HRESP_OKAY;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (addr_q)
            IDX_FIRST_DATA: begin
                rd_d[3:0] = (dir_w[3:0] & latch_w[3:0]) | (~dir_w[3:0] & pin_i[3:0]);
            end
            IDX_SECOND_DATA: begin
                rd_d[3:0] = (dir_w[7:4] & latch_w[7:4]) | (~dir_w[7:4] & pin_i[7:4]);
            end
            IDX_THIRD_DATA: begin
                rd_d[3:0] = (dir_w[11:8] & latch_w[11:8]) | (~dir_w[11:8] & pin_i[11:8]);
            end
            IDX_ALT_SELECT: begin
                rd_d[1:0] = alt_q;
            end
            default: begin
                rd_d = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (mc_q == MC_S2 && !wr_q) begin
            hrdata <= rd_d;
        end
    end

    // ------------------------------------------------------------
    // write path
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_q <= {NPORT{DATA_RESET}};
        end else if (mc_q == MC_S3 && wr_q) begin
            if (addr_q == IDX_FIRST_DATA) begin
                data_q[0] <= hwdata[3:0];
            end
            if (addr_q == IDX_SECOND_DATA) begin
                data_q[1] <= hwdata[3:0];
            end
            if (addr_q == IDX_THIRD_DATA) begin
                data_q[2] <= hwdata[3:0];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= {NPIN{CTRL_RESET}};
        end else if (mc_q == MC_S3 && wr_q) begin
            for (int i = 0; i < NPIN; i++) begin
                if (addr_q == IDX_PIN_CTRL + 8'(i)) begin
                    ctrl_q[i] <= hwdata[3:0];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pull_up_q <= PULL_RESET;
            alt_q     <= ALT_RESET;
        end else if (mc_q == MC_S3 && wr_q) begin
            if (addr_q == IDX_SHARED_CTRL) begin
                pull_up_q <= hwdata[PULL_BIT];
            end
            if (addr_q == IDX_ALT_SELECT) begin
                alt_q <= hwdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // 64 Hz sampling tick
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (div_q == DIV_W'(SAMPLE_CYCLES - 1)) begin
            div_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + DIV_W'(1);
            tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // output value select and pin array
    // ------------------------------------------------------------
    always_comb begin
        out_w = latch_w;
        if (alt_q[ALT_TXD]) begin
            out_w[PIN_TXD] = serial_tx_data;
        end
        if (alt_q[ALT_OVF]) begin
            out_w[PIN_OVF] = timer_overflow_flag;
        end
    end

    for (genvar g = 0; g < NPIN; g++) begin : g_pin
        assign dir_w[g] = ctrl_q[g][CTL_DIR];
        tnp_pin u_pin (
            .clk     (clk),
            .reset_n (reset_n),
            .ctrl    (ctrl_q[g]),
            .pull_up (pull_up_q),
            .out_val (out_w[g]),
            .pin_in  (pin_i[g]),
            .tick    (tick_q),
            .pin_out (pin_o[g]),
            .pin_oe  (pin_oe[g]),
            .pu_en   (pin_pu_en[g]),
            .pd_en   (pin_pd_en[g]),
            .irq     (pin_irq[g])
        );
    end

    // ------------------------------------------------------------
    // secondary inputs to timer and serial port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_capture_trigger <= 1'b0;
            serial_rx_data        <= 1'b0;
            timer_external_clock  <= 1'b0;
        end else begin
            timer_capture_trigger <= pin_i[PIN_TRG];
            serial_rx_data        <= pin_i[PIN_RXD];
            timer_external_clock  <= pin_i[PIN_ECK];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    AST_WRITE_AT_S3: assert property (
        (mc_q == MC_S3 && wr_q && addr_q == IDX_FIRST_DATA)
        |=> data_q[0] == $past(hwdata[3:0]))
        else $error("first port latch not written at S3");

    AST_PIN_DRIVEN: assert property (
        (ctrl_q[0][CTL_DIR] && !ctrl_q[0][CTL_MOD] && !alt_q[ALT_TXD])
        |=> pin_oe[0] && pin_o[0] == $past(data_q[0][0]))
        else $error("output pin not driven from latch");

    AST_READ_MIX: assert property (
        (mc_q == MC_S2 && !wr_q && addr_q == IDX_FIRST_DATA)
        |=> hrdata[3:0] == (($past(dir_w[3:0]) & $past(latch_w[3:0]))
                          | (~$past(dir_w[3:0]) & $past(pin_i[3:0]))))
        else $error("read does not mix latch and pin per direction");

    AST_READY_TIMING: assert property (
        accept |=> !hreadyout [*3] ##1 hreadyout)
        else $error("data phase length wrong");

    AST_TRIGGER_FORWARD: assert property (
        reset_n |=> timer_capture_trigger == $past(pin_i[PIN_TRG]))
        else $error("capture trigger not forwarded");

    AST_EXT_CLOCK_FORWARD: assert property (
        reset_n |=> timer_external_clock == $past(pin_i[PIN_ECK]))
        else $error("external count clock not forwarded");

    AST_TXD_OUT: assert property (
        (alt_q[ALT_TXD] && ctrl_q[PIN_TXD][CTL_DIR] && !ctrl_q[PIN_TXD][CTL_MOD])
        |=> pin_o[PIN_TXD] == $past(serial_tx_data))
        else $error("transmit data not on third port bit 2");

    AST_PULL_SHARED: assert property (
        (pin_pu_en != 12'h000) |-> $past(pull_up_q))
        else $error("pull-up without shared select");

    AST_IRQ_CHANGE: assert property (
        (ctrl_q[0][CTL_IE] && ctrl_q[0][CTL_FSEL] && $stable(ctrl_q[0])
         && pin_i[0] != $past(pin_i[0]))
        |=> pin_irq[0])
        else $error("level change missed by fast sampling");

    AST_TICK_PULSE: assert property (
        tick_q |=> !tick_q)
        else $error("sampling tick longer than one cycle");

endmodule : tnp_ports

/* verif/tnp_ext_equipment.sv */
// external equipment wired to the twelve general purpose pins
// assumes device pin outputs are registers on clk; bench sets the equipment drive
module tnp_ext_equipment
    import tnp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [11:0] pin_o,
    input  wire logic [11:0] pin_oe,
    input  wire logic [11:0] pin_pu_en,
    input  wire logic [11:0] pin_pd_en,
    input  wire logic [11:0] ext_val,
    input  wire logic [11:0] ext_oe,
    output logic [11:0]      pin_i
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [11:0] last_q = 12'h000;

    // ------------------------------------------------------------
    // wire level: device, equipment, pull resistor, else floating
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (pin_oe[i])
                pin_i[i] = pin_o[i];
            else if (ext_oe[i])
                pin_i[i] = ext_val[i];
            else if (pin_pu_en[i])
                pin_i[i] = 1'b1;
            else if (pin_pd_en[i])
                pin_i[i] = 1'b0;
            else
                pin_i[i] = ~last_q[i];
        end
    end

    always @(posedge clk) last_q <= pin_i;

endmodule : tnp_ext_equipment

/* verif/tb_top.sv */
// self-checking bench for the three nibble io ports
// assumes tnp_ports as one AHB-Lite slave and the external equipment model
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tnp_pkg::*;

    logic        clk        = 1'b0;
    logic        reset_n    = 1'b0;
    logic        hsel       = 1'b0;
    logic [31:0] haddr      = 32'h0;
    logic [1:0]  htrans     = 2'h0;
    logic        hwrite     = 1'b0;
    logic [31:0] hwdata     = 32'h0;
    logic [11:0] ext_val    = 12'h000;
    logic [11:0] ext_oe     = 12'h000;
    logic        tx         = 1'b0;
    logic        ovf        = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [11:0] pin_i;
    logic [11:0] pin_o;
    logic [11:0] pin_oe;
    logic [11:0] pin_pu_en;
    logic [11:0] pin_pd_en;
    logic [11:0] pin_irq;
    logic        capt;
    logic        rxd;
    logic        ext_clk;
    logic        rdy_s;
    logic        rsp_s;
    logic [31:0] rd_s;
    logic [11:0] po_s;
    int          n_mismatch = 0;
    int          comparisons = 0;

    tnp_ports #(.SAMPLE_CYCLES(16)) i_tnp_ports (
        .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu_en(pin_pu_en), .pin_pd_en(pin_pd_en),
        .pin_irq(pin_irq), .serial_tx_data(tx), .timer_overflow_flag(ovf),
        .timer_capture_trigger(capt), .serial_rx_data(rxd), .timer_external_clock(ext_clk)
    );

    tnp_ext_equipment i_tnp_ext_equipment (
        .clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu_en(pin_pu_en),
        .pin_pd_en(pin_pd_en), .ext_val(ext_val), .ext_oe(ext_oe), .pin_i(pin_i)
    );

    always #2.5 clk = ~clk;

    // values as they stand just before each rising edge
    always @(negedge clk) begin
        rdy_s <= hreadyout;
        rsp_s <= hresp;
        rd_s  <= hrdata;
        po_s  <= pin_o;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [3:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {22'h0, idx, 2'h0};
        do begin
            @(posedge clk);
        end while (rdy_s !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {28'h0, wd};
        do begin
            @(posedge clk);
        end while (rdy_s !== 1'b1);
        rd = rd_s;
        chk("hresp", 32'h0, 32'(rsp_s));
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [3:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask : wr

    task automatic rdc(input string name, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, idx, 4'h0, x);
        chk(name, exp, x);
    endtask : rdc

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        ext_oe  <= 12'hFFF;
        ext_val <= 12'hFFF;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("pd_en", 32'hFFF, 32'(pin_pd_en));
        chk("pu_en", 32'h0, 32'(pin_pu_en));
        chk("oe", 32'h0, 32'(pin_oe));
        for (int p = 0; p < NPORT; p++) rdc("pin read", 8'(p), 32'hF);
        ext_oe <= 12'h000;
        for (int i = 0; i < NPIN; i++) wr(IDX_PIN_CTRL + 8'(i), 4'h2);
        @(negedge clk);
        chk("oe", 32'hFFF, 32'(pin_oe));
        chk("pin_o", 32'h0, 32'(pin_o));
        for (int p = 0; p < NPORT; p++) rdc("latch", 8'(p), 32'h0);
    endtask : t_reset

    task automatic t_mix();
        logic [3:0] cfg [4] = '{4'h2, 4'h0, 4'h3, 4'h1};
        ext_oe  <= 12'hEEE;
        ext_val <= 12'h222;
        for (int i = 0; i < NPIN; i++) wr(IDX_PIN_CTRL + 8'(i), cfg[i % 4]);
        @(negedge clk);
        chk("oe", 32'h555, 32'(pin_oe));
        chk("pd_en", 32'h222, 32'(pin_pd_en));
        for (int p = 0; p < NPORT; p++) begin
            wr(8'(p), 4'h5);
            chk("pin before", 32'h0, 32'(po_s[4 * p]));
            @(negedge clk);
            chk("pin after", 32'h1, 32'(pin_o[4 * p]));
            rdc("mixed read", 8'(p), 32'h7);
        end
        @(negedge clk);
        chk("oe", 32'h111, 32'(pin_oe));
        wr(IDX_SHARED_CTRL, 4'h1);
        @(negedge clk);
        chk("pu_en", 32'h222, 32'(pin_pu_en));
        chk("pd_en", 32'h0, 32'(pin_pd_en));
        rdc("ctrl read", IDX_SHARED_CTRL, 32'h0);
        for (int p = 0; p < NPORT; p++) begin
            wr(8'(p), 4'h0);
            rdc("mixed read", 8'(p), 32'h2);
        end
        @(negedge clk);
        chk("oe", 32'h555, 32'(pin_oe));
        rdc("unmapped", 8'h30, 32'h0);
    endtask : t_mix

    task automatic t_alt();
        for (int i = 0; i < 3; i++) wr(IDX_PIN_CTRL + 8'(i), 4'h1);
        wr(IDX_PIN_CTRL + 8'(PIN_TXD), 4'h2);
        wr(IDX_PIN_CTRL + 8'(PIN_OVF), 4'h2);
        ext_oe <= 12'hEEF;
        for (int v = 0; v < 8; v++) begin
            @(posedge clk);
            ext_val <= {8'h22, 1'b0, 3'(v)};
            @(posedge clk);
            @(negedge clk);
            chk("alt in", 32'(v), 32'({ext_clk, rxd, capt}));
        end
        wr(IDX_ALT_SELECT, 4'h3);
        for (int v = 0; v < 4; v++) begin
            @(posedge clk);
            {ovf, tx} <= 2'(v);
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("alt out", 32'(v), 32'(pin_o[11:10]));
        end
        rdc("alt select", IDX_ALT_SELECT, 32'h3);
        wr(IDX_ALT_SELECT, 4'h0);
        @(negedge clk);
        chk("latch out", 32'h0, 32'(pin_o[11:10]));
    endtask : t_alt

    task automatic t_irq();
        int cnt [3] = '{0, 0, 0};
        int early = 0;
        @(posedge clk);
        ext_oe  <= 12'hFFF;
        ext_val <= 12'h000;
        wr(IDX_PIN_CTRL + 8'h00, 4'hD);
        wr(IDX_PIN_CTRL + 8'h01, 4'h9);
        wr(IDX_PIN_CTRL + 8'h02, 4'h5);
        repeat (40) @(posedge clk);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            ext_val <= ext_val ^ 12'h007;
            for (int c = 0; c < 40; c++) begin
                @(negedge clk);
                for (int j = 0; j < 3; j++) cnt[j] += int'(pin_irq[j] === 1'b1);
                early += int'(c < 4 && pin_irq[0] === 1'b1);
            end
        end
        chk("irq fast", 32'h2, 32'(cnt[0]));
        chk("irq fast early", 32'h2, 32'(early));
        chk("irq slow", 32'h2, 32'(cnt[1]));
        chk("irq off", 32'h0, 32'(cnt[2]));
    endtask : t_irq

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_mix();
        t_alt();
        t_irq();
        wrap_up();
    end

    initial begin
        #50000;
        n_mismatch++;
        wrap_up();
    end

endmodule : tb_top
